// >>> hw/redriver_control_pin_decode.sv
// Control-pin decode, hot-plug timeout and strap capture for the redriver crosspoint.
module redriver_control_pin_decode #(
    parameter int HPD_TIMEOUT = redriver_pkg::HPD_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Four-level straps
    input wire logic [1:0] configSel,
    input wire logic [1:0] display_eq_sel_hi,
    input wire logic [1:0] display_eq_sel_lo,
    input wire logic [1:0] upstream_eq_sel_hi,
    input wire logic [1:0] upstream_eq_sel_lo,
    // Shared control pins
    input wire logic flipSclPin,
    input wire logic usbSdaPin,
    input wire logic display_path_enable,
    // Register setting from the I2C register file
    input wire logic regDisplayEnable,
    // Decoded controls
    output logic i2cMode,
    output logic i2cTestMode,
    output logic i2cLowVolt,
    output logic adaptiveEqEnable,
    output logic strapsValid,
    output logic flip,
    output logic usb_path_enable,
    output logic i2cScl,
    output logic i2cSda,
    output logic hot_plug_in,
    output logic displayLanesEnable,
    output logic auxToSbu1,
    output logic auxToSbu2,
    output logic [3:0] displayEqGain,
    output logic [3:0] upstreamEqGain,
    output logic [1:0] addrStrap
);
    typedef enum logic [1:0] {
        CAPTURE = 2'b01,
        RUN = 2'b10
    } state_e;

    state_e state, next_state;
    logic [1:0] mode, next_mode;
    logic [3:0] next_displayEqGain, next_upstreamEqGain;
    logic [1:0] next_addrStrap;
    logic next_strapsValid;

    // Straps and pins come from outside, so each passes two flops first.
    logic [1:0] cfgS1, cfgS2, dhS1, dhS2, dlS1, dlS2, uhS1, uhS2, ulS1, ulS2;
    logic flipS1, flipS2, usbS1, usbS2, dpeS1, dpeS2;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfgS1 <= 2'h0;
            cfgS2 <= 2'h0;
            dhS1 <= 2'h0;
            dhS2 <= 2'h0;
            dlS1 <= 2'h0;
            dlS2 <= 2'h0;
            uhS1 <= 2'h0;
            uhS2 <= 2'h0;
            ulS1 <= 2'h0;
            ulS2 <= 2'h0;
            flipS1 <= 1'b0;
            flipS2 <= 1'b0;
            usbS1 <= 1'b0;
            usbS2 <= 1'b0;
            dpeS1 <= 1'b0;
            dpeS2 <= 1'b0;
        end else begin
            cfgS1 <= configSel;
            cfgS2 <= cfgS1;
            dhS1 <= display_eq_sel_hi;
            dhS2 <= dhS1;
            dlS1 <= display_eq_sel_lo;
            dlS2 <= dlS1;
            uhS1 <= upstream_eq_sel_hi;
            uhS2 <= uhS1;
            ulS1 <= upstream_eq_sel_lo;
            ulS2 <= ulS1;
            flipS1 <= flipSclPin;
            flipS2 <= flipS1;
            usbS1 <= usbSdaPin;
            usbS2 <= usbS1;
            dpeS1 <= display_path_enable;
            dpeS2 <= dpeS1;
        end
    end

    // Strap capture: a short settle lets the synchronisers fill before sampling.
    logic [1:0] settle, next_settle;

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_displayEqGain = displayEqGain;
        next_upstreamEqGain = upstreamEqGain;
        next_addrStrap = addrStrap;
        next_strapsValid = strapsValid;
        next_settle = settle;
        case (state)
            CAPTURE: begin
                if (settle != redriver_pkg::SETTLE_LAST) begin
                    next_settle = settle + 2'h1;
                end else begin
                    next_mode = cfgS2;
                    next_displayEqGain = {dhS2, dlS2};
                    next_upstreamEqGain = {uhS2, ulS2};
                    if (cfgS2 != redriver_pkg::STRAP_ZERO) begin
                        next_addrStrap = {dlS2[0], ulS2[0]};
                    end
                    next_strapsValid = 1'b1;
                    next_state = RUN;
                end
            end
            RUN: begin
                next_state = RUN;
            end
            default: begin
                next_state = CAPTURE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= CAPTURE;
            mode <= redriver_pkg::STRAP_ZERO;
            displayEqGain <= redriver_pkg::EQ_RESET;
            upstreamEqGain <= redriver_pkg::EQ_RESET;
            addrStrap <= redriver_pkg::ADDR_RESET;
            strapsValid <= 1'b0;
            settle <= 2'h0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            displayEqGain <= next_displayEqGain;
            upstreamEqGain <= next_upstreamEqGain;
            addrStrap <= next_addrStrap;
            strapsValid <= next_strapsValid;
            settle <= next_settle;
        end
    end

    // Hot-plug low timer; saturates so a long unplug does not wrap.
    logic [redriver_pkg::HPD_CNT_W-1:0] hpdCnt, next_hpdCnt;
    logic hpdLost, next_hpdLost;
    logic modeI2c;
    assign modeI2c = (mode != redriver_pkg::STRAP_ZERO);

    always_comb begin
        next_hpdCnt = hpdCnt;
        next_hpdLost = hpdLost;
        if (!modeI2c || dpeS2) begin
            next_hpdCnt = '0;
            next_hpdLost = 1'b0;
        end else if (hpdCnt > HPD_TIMEOUT[redriver_pkg::HPD_CNT_W-1:0]) begin
            next_hpdLost = 1'b1;
        end else begin
            next_hpdCnt = hpdCnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hpdCnt <= '0;
            hpdLost <= 1'b0;
        end else begin
            hpdCnt <= next_hpdCnt;
            hpdLost <= next_hpdLost;
        end
    end

    // Output decode, registered so every output comes from a flop.
    logic next_i2cMode, next_i2cTestMode, next_i2cLowVolt, next_adaptiveEqEnable;
    logic next_flip, next_usb_path_enable, next_i2cScl, next_i2cSda, next_hot_plug_in;
    logic next_displayLanesEnable, next_auxToSbu1, next_auxToSbu2;

    always_comb begin
        next_i2cMode = modeI2c && strapsValid;
        next_i2cTestMode = strapsValid && (mode == redriver_pkg::STRAP_R);
        next_i2cLowVolt = strapsValid && (mode == redriver_pkg::STRAP_F);
        next_adaptiveEqEnable = strapsValid && modeI2c;
        next_flip = modeI2c ? flip : flipS2;
        next_i2cScl = modeI2c ? flipS2 : 1'b1;
        next_usb_path_enable = modeI2c ? 1'b0 : usbS2;
        next_i2cSda = modeI2c ? usbS2 : 1'b1;
        next_hot_plug_in = modeI2c ? dpeS2 : 1'b0;
        if (!strapsValid) begin
            next_displayLanesEnable = 1'b0;
        end else if (modeI2c) begin
            next_displayLanesEnable = regDisplayEnable && !hpdLost;
        end else begin
            next_displayLanesEnable = dpeS2;
        end
        // The aux switch stays closed after hot-plug loss; only orientation steers it.
        next_auxToSbu1 = strapsValid && !next_flip;
        next_auxToSbu2 = strapsValid && next_flip;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            i2cMode <= 1'b0;
            i2cTestMode <= 1'b0;
            i2cLowVolt <= 1'b0;
            adaptiveEqEnable <= 1'b0;
            flip <= 1'b0;
            usb_path_enable <= 1'b0;
            i2cScl <= 1'b1;
            i2cSda <= 1'b1;
            hot_plug_in <= 1'b0;
            displayLanesEnable <= 1'b0;
            auxToSbu1 <= 1'b0;
            auxToSbu2 <= 1'b0;
        end else begin
            i2cMode <= next_i2cMode;
            i2cTestMode <= next_i2cTestMode;
            i2cLowVolt <= next_i2cLowVolt;
            adaptiveEqEnable <= next_adaptiveEqEnable;
            flip <= next_flip;
            usb_path_enable <= next_usb_path_enable;
            i2cScl <= next_i2cScl;
            i2cSda <= next_i2cSda;
            hot_plug_in <= next_hot_plug_in;
            displayLanesEnable <= next_displayLanesEnable;
            auxToSbu1 <= next_auxToSbu1;
            auxToSbu2 <= next_auxToSbu2;
        end
    end

    // Assertions.
    sequence hpdLowLong;
        hpdLost && modeI2c;
    endsequence

    hpd_loss_lanes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hpdLowLong |=> !displayLanesEnable)
        else $error("display lanes on after hot-plug loss");
    hpd_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dpeS2 |=> hpdCnt == '0 && !hpdLost)
        else $error("hot-plug timer not restarted");
    aux_switch_closed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapsValid |=> auxToSbu1 != auxToSbu2)
        else $error("aux switch open");
    aux_orient_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapsValid |=> auxToSbu2 == flip)
        else $error("aux routed against orientation");
    flip_discrete_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && !modeI2c) |=> flip == $past(flipS2))
        else $error("flip not following pin");
    usb_discrete_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && !modeI2c) |=> usb_path_enable == $past(usbS2) && i2cSda)
        else $error("usb enable not following pin");
    disp_discrete_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && !modeI2c) |=> displayLanesEnable == $past(dpeS2))
        else $error("display lanes not following pin");
    disp_reg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && modeI2c && !hpdLost) |=> displayLanesEnable == $past(regDisplayEnable))
        else $error("display lanes not following register");
    hpd_input_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && modeI2c) |=> hot_plug_in == $past(dpeS2))
        else $error("hot-plug input not passed");
    straps_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapsValid |=> $stable(mode) && $stable(displayEqGain) && $stable(addrStrap))
        else $error("strap decode changed after capture");

    // The single edge at which the synchronised straps are taken.
    sequence strapCapture;
        state == CAPTURE && settle == redriver_pkg::SETTLE_LAST;
    endsequence

    disp_eq_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapCapture |=> strapsValid && displayEqGain == {$past(dhS2), $past(dlS2)})
        else $error("display gain not taken from straps");
    up_eq_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapCapture |=> upstreamEqGain == {$past(uhS2), $past(ulS2)})
        else $error("upstream gain not taken from straps");
    addr_discrete_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapCapture ##0 (cfgS2 == redriver_pkg::STRAP_ZERO) |=> addrStrap == redriver_pkg::ADDR_RESET)
        else $error("address bits set in discrete mode");
    addr_i2c_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapCapture ##0 (cfgS2 != redriver_pkg::STRAP_ZERO) |=>
            addrStrap == {$past(dlS2[0]), $past(ulS2[0])})
        else $error("address bits not taken from low straps");
    scl_i2c_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && modeI2c) |=> i2cScl == $past(flipS2))
        else $error("clock pin not passed in I2C mode");
    sda_i2c_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strapsValid && modeI2c) |=> i2cSda == $past(usbS2) && !usb_path_enable)
        else $error("data pin not passed in I2C mode");
    mode_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapsValid |=> i2cTestMode == ($past(mode) == redriver_pkg::STRAP_R) &&
            i2cLowVolt == ($past(mode) == redriver_pkg::STRAP_F))
        else $error("mode flags do not match strap code");
    aeq_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strapsValid |=> adaptiveEqEnable == $past(modeI2c) && i2cMode == $past(modeI2c))
        else $error("adaptive equalization or I2C flag wrong");
    hpd_timeout_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (modeI2c && !dpeS2 && hpdCnt > HPD_TIMEOUT[redriver_pkg::HPD_CNT_W-1:0]) |=> hpdLost)
        else $error("hot-plug loss not flagged after timeout");
endmodule // redriver_control_pin_decode

// >>> hw/redriver_pkg.sv
// Shared constants for the redriver control-pin decode block.
package redriver_pkg;
    // Four-level strap codes.
    localparam logic [1:0] STRAP_ZERO = 2'h0;
    localparam logic [1:0] STRAP_ONE = 2'h1;
    localparam logic [1:0] STRAP_R = 2'h2;
    localparam logic [1:0] STRAP_F = 2'h3;
    // Clock and hot-plug timeout.
    localparam int CLK_MHZ = 100;
    localparam int HPD_TIMEOUT_US = 2000;
    localparam int HPD_TIMEOUT_CYCLES = HPD_TIMEOUT_US * CLK_MHZ;
    localparam int HPD_CNT_W = 18;
    // Last value of the settle counter before the straps are taken.
    localparam logic [1:0] SETTLE_LAST = 2'h3;
    // Reset values.
    localparam logic [3:0] EQ_RESET = 4'h0;
    localparam logic [1:0] ADDR_RESET = 2'h0;
endpackage

// >>> verif/policy_model.sv
// Port policy controller model that drives the shared control pins of the block.
module policy_model (
    // Clock
    input wire logic sys_clk,
    // Requests from the bench: flip or clock, usb or data, display or hot-plug, register
    input wire logic [3:0] req,
    // Pins toward the block
    output logic flipSclPin,
    output logic usbSdaPin,
    output logic display_path_enable,
    output logic regDisplayEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {regDisplayEnable, display_path_enable, usbSdaPin, flipSclPin} = 4'h0;
    end
    // Requests are taken at the edge, before the bench moves them, and the pins
    // follow just after it, as a real controller's outputs do.
    always @(posedge sys_clk) begin
        flipSclPin <= #1 req[0];
        usbSdaPin <= #1 req[1];
        display_path_enable <= #1 req[2];
        regDisplayEnable <= #1 req[3];
    end
endmodule // policy_model

// >>> verif/tb_redriver_control_pin_decode.sv
// Self-checking bench for the redriver control-pin decode block.
module tb_redriver_control_pin_decode;
    timeunit 1ns;
    timeprecision 1ps;
    // A short timeout keeps the hot-plug scenario brief.
    localparam int TO = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] configSel = 2'h0;
    logic [1:0] display_eq_sel_hi = 2'h0;
    logic [1:0] display_eq_sel_lo = 2'h0;
    logic [1:0] upstream_eq_sel_hi = 2'h0;
    logic [1:0] upstream_eq_sel_lo = 2'h0;
    logic [3:0] req = 4'h0;
    logic flipSclPin, usbSdaPin, display_path_enable, regDisplayEnable;
    logic i2cMode, i2cTestMode, i2cLowVolt, adaptiveEqEnable, strapsValid, flip;
    logic usb_path_enable, i2cScl, i2cSda, hot_plug_in, displayLanesEnable;
    logic auxToSbu1, auxToSbu2;
    logic [3:0] displayEqGain, upstreamEqGain;
    logic [1:0] addrStrap;
    int bad_count = 0;
    int tests_run = 0;

    policy_model policy_model_inst (.sys_clk, .req, .flipSclPin, .usbSdaPin,
        .display_path_enable, .regDisplayEnable);

    redriver_control_pin_decode #(.HPD_TIMEOUT(TO)) redriver_control_pin_decode_inst (
        .sys_clk, .rst_n, .configSel, .display_eq_sel_hi, .display_eq_sel_lo,
        .upstream_eq_sel_hi, .upstream_eq_sel_lo, .flipSclPin, .usbSdaPin,
        .display_path_enable, .regDisplayEnable, .i2cMode, .i2cTestMode, .i2cLowVolt,
        .adaptiveEqEnable, .strapsValid, .flip, .usb_path_enable, .i2cScl, .i2cSda,
        .hot_plug_in, .displayLanesEnable, .auxToSbu1, .auxToSbu2, .displayEqGain,
        .upstreamEqGain, .addrStrap);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [3:0] s, input logic [3:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Straps are set before reset so that they are settled when captured.
    task automatic boot(input logic [1:0] c, a, b, x, y);
        configSel = c;
        display_eq_sel_hi = a;
        display_eq_sel_lo = b;
        upstream_eq_sel_hi = x;
        upstream_eq_sel_lo = y;
        rst_n = 1'b0;
        step(4);
        rst_n = 1'b1;
        step(8);
    endtask

    task automatic discrete_mode;
        boot(2'h0, 2'h2, 2'h1, 2'h3, 2'h0);
        chk(displayEqGain, 4'h9);
        chk(upstreamEqGain, 4'hc);
        chk(4'({i2cMode, adaptiveEqEnable}), 4'h0);
        chk(4'(addrStrap), 4'h0);
        configSel = 2'h1;
        display_eq_sel_lo = 2'h3;
        step(8);
        chk(4'({i2cMode, strapsValid}), 4'h1);
        chk(displayEqGain, 4'h9);
        for (int i = 0; i < 8; i++) begin
            req = {~i[2], i[2:0]};
            step(8);
            chk(4'(flip), 4'(i[0]));
            chk(4'(usb_path_enable), 4'(i[1]));
            chk(4'(displayLanesEnable), 4'(i[2]));
            chk(4'({auxToSbu1, auxToSbu2}), 4'({~i[0], i[0]}));
            chk(4'({i2cScl, i2cSda}), 4'h3);
        end
    endtask

    task automatic i2c_modes;
        for (int c = 1; c < 4; c++) begin
            boot(2'(c), 2'h0, 2'(c), 2'h1, 2'(~c));
            chk({i2cMode, i2cTestMode, i2cLowVolt, adaptiveEqEnable},
                {1'b1, c == 2, c == 3, 1'b1});
            chk(4'(addrStrap), 4'({c[0], ~c[0]}));
            for (int i = 0; i < 16; i++) begin
                req = i[3:0];
                step(8);
                chk(4'({i2cScl, i2cSda, usb_path_enable}), 4'({i[0], i[1], 1'b0}));
                chk(4'(hot_plug_in), 4'(i[2]));
                if (i[2]) chk(4'(displayLanesEnable), 4'(i[3]));
            end
        end
    endtask

    // Two lows shorter than the timeout, split by a brief high, must not trip it.
    task automatic hpd_loss;
        boot(2'h1, 2'h0, 2'h0, 2'h0, 2'h0);
        req = 4'hc;
        step(8);
        chk(4'(displayLanesEnable), 4'h1);
        req = 4'h8;
        step(15);
        req = 4'hc;
        step(2);
        req = 4'h8;
        step(15);
        chk(4'(displayLanesEnable), 4'h1);
        step(15);
        chk(4'(displayLanesEnable), 4'h0);
        chk(4'(auxToSbu1 | auxToSbu2), 4'h1);
    endtask

    initial begin
        discrete_mode();
        i2c_modes();
        hpd_loss();
        conclude();
    end

    // The scenarios need well under 2000 cycles.
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
endmodule // tb_redriver_control_pin_decode
